// ### rtl/status_byte_summarizer.sv
// Purpose: Gathers group summaries into the status byte, makes MSS, RQS and SRQ.
// Assumes: Summaries are held low by their groups while clear-status acts.
// Notes: Poll and query reads are one-cycle strobes from the bus logic on clk.
`timescale 1ns/100ps
`default_nettype none
`include "status_byte_map.svh"
// Notes on behaviour
// - An eight-bit status byte summarizes the groups plus the RQS or MSS indication.
// - Each group bit follows its group summary continuously.
// - Bit 7 carries the operation status group summary.
// - Bit 5 carries the standard event status summary.
// - Bit 4 is message-available, high while the output queue holds data.
// - Bit 3 is questionable, bit 1 hardware group two, bit 0 hardware group one, bit 2 unused.
// - Bit 6 reads RQS on a serial poll and MSS on a query; other bits are the same.
// - On a serial poll bit 6 is 1 only while SRQ is asserted.
// - A serial poll clears RQS and leaves the other bits unchanged.
// - MSS is the OR of the status byte ANDed with the enable mask, bit 6 excluded.
// - A query read changes no bit.
// - The query answer is the weighted sum 0 to 187 of the byte with 64 added when MSS is true.
// - A group may reach the byte through another group that maps into it.
// - The status byte is not writable; it moves only with the summaries.
// - Clear-status clears event summaries and RQS but not message-available.
// - MSS going from false to true raises SRQ and sets RQS.
module status_byte_summarizer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Group summaries
  input wire logic hw1_sum,
  input wire logic hw2_sum,
  input wire logic ques_sum,
  input wire logic mav,
  input wire logic esb_sum,
  input wire logic oper_sum,
  // Controller side
  input wire status_byte_pkg::sbyte_t sre_mask,
  input wire logic clear_status,
  input wire logic poll_rd,
  input wire logic query_rd,
  // Results
  output status_byte_pkg::sbyte_t status_byte,
  output status_byte_pkg::sbyte_t poll_byte,
  output status_byte_pkg::sbyte_t query_byte,
  output logic read_valid,
  output logic srq,
  output logic mss
);
  import status_byte_pkg::*;

  status_summary_if sum_if ();
  logic [`SB_WIDTH-1:0] raw;
  sbyte_t sb_d;
  sbyte_t sb_q;
  sbyte_t sre_q;
  logic mss_d;
  logic mss_q;
  logic svc_prev_q;
  logic rqs_q;
  logic rise;

  // Each summary lands on its own bit; bits 2 and 6 stay low in the raw vector.
  always_comb begin
    raw = `SB_RESET;
    raw[`SB_BIT_HW1] = hw1_sum;
    raw[`SB_BIT_HW2] = hw2_sum;
    raw[`SB_BIT_QUES] = ques_sum;
    raw[`SB_BIT_MAV] = mav;
    raw[`SB_BIT_ESB] = esb_sum;
    raw[`SB_BIT_OPER] = oper_sum;
  end

  summary_sync u_sync (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .raw(raw),
    .out(sum_if)
  );

  // Status byte has no write path; it only follows the summaries.
  always_comb begin
    sb_d = sum_if.sum;
    sb_d[`SB_BIT_RQS] = 1'b0;
    sb_d[`SB_BIT_UNUSED] = 1'b0;
  end

  // Bit 6 is masked out so that MSS never feeds back on itself.
  assign mss_d = |(sb_d & sre_q & `SB_MSS_MASK);

  // Level-triggered would re-request forever after a poll, so only a rise counts.
  // Taking the rise from mss_q lines RQS, SRQ and mss up on one edge.
  assign rise = mss_q & ~svc_prev_q;

  // The byte with bits 2 and 6 cleared, one edge after the synchroniser.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sb_q <= `SB_RESET;
    end else if (clk_en) begin
      sb_q <= sb_d;
    end
  end

  // The mask already comes from logic on clk, so one register is enough.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sre_q <= `SRE_RESET;
    end else if (clk_en) begin
      sre_q <= sre_mask;
    end
  end

  // MSS of the same byte that sb_q holds.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mss_q <= 1'b0;
    end else if (clk_en) begin
      mss_q <= mss_d;
    end
  end

  // Resets low like mss_q, so no false rise follows reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      svc_prev_q <= 1'b0;
    end else if (clk_en) begin
      svc_prev_q <= mss_q;
    end
  end

  // A new rise wins over a poll or clear in the same cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rqs_q <= 1'b0;
    end else if (clk_en) begin
      if (rise) begin
        rqs_q <= 1'b1;
      end else if (poll_rd || clear_status) begin
        rqs_q <= 1'b0;
      end
    end
  end

  // SRQ is kept as a copy of RQS, so a poll reads bit 6 exactly as SRQ stands.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      srq <= 1'b0;
    end else if (clk_en) begin
      if (rise) begin
        srq <= 1'b1;
      end else if (poll_rd || clear_status) begin
        srq <= 1'b0;
      end
    end
  end

  // The live byte, one register behind sb_q so that it lines up with mss.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_byte <= `SB_RESET;
    end else if (clk_en) begin
      status_byte <= sb_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mss <= 1'b0;
    end else if (clk_en) begin
      mss <= mss_q;
    end
  end

  // One pulse for every taken read, whichever the method.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_valid <= 1'b0;
    end else if (clk_en) begin
      read_valid <= poll_rd | query_rd;
    end
  end

  // Reads take the byte as it stands on the outputs, so both methods agree with it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      poll_byte <= `SB_RESET;
    end else if (clk_en) begin
      if (poll_rd) begin
        poll_byte <= status_byte | (sbyte_t'(rqs_q) << `SB_BIT_RQS);
      end
    end
  end

  // A query only copies; it leaves RQS and SRQ alone.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      query_byte <= `SB_RESET;
    end else if (clk_en) begin
      if (query_rd) begin
        query_byte <= status_byte | (sbyte_t'(mss) << `SB_BIT_RQS);
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/status_byte_map.svh
// Purpose: Bit positions, the MSS mask, reset values and sizes of the status byte.
// Assumes: Included by bare name from the package and the design modules.
// Notes: Definitions only.
`ifndef STATUS_BYTE_MAP_SVH
`define STATUS_BYTE_MAP_SVH

`define SB_WIDTH 8
`define SB_BIT_HW1 0
`define SB_BIT_HW2 1
`define SB_BIT_UNUSED 2
`define SB_BIT_QUES 3
`define SB_BIT_MAV 4
`define SB_BIT_ESB 5
`define SB_BIT_RQS 6
`define SB_BIT_OPER 7
`define SB_RESET 8'h00
`define SB_MSS_MASK 8'hBF
`define SRE_RESET 8'h00
`define SB_SYNC_STAGES 2

`endif

// ### rtl/status_byte_pkg.sv
// Purpose: Types shared by the status byte summarizer files.
// Assumes: Map header holds the numbers.
// Notes: Types only.
`include "status_byte_map.svh"
package status_byte_pkg;
  typedef logic [`SB_WIDTH-1:0] sbyte_t;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_POLL,
    RD_QUERY
  } read_kind_t;
endpackage

// ### rtl/status_summary_if.sv
// Purpose: Carries the summary inputs from the synchroniser to the main block.
// Assumes: Both ends share clk.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
`include "status_byte_map.svh"
interface status_summary_if;
  logic [`SB_WIDTH-1:0] sum;
  modport src (output sum);
  modport dst (input sum);
endinterface
`default_nettype wire

// ### rtl/summary_sync.sv
// Purpose: Two-stage synchroniser for the group summary messages.
// Assumes: Summaries come from logic outside this clock domain.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
`include "status_byte_map.svh"
module summary_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Raw summaries
  input wire logic [`SB_WIDTH-1:0] raw,
  // Synchronised summaries
  status_summary_if.src out
);
  import status_byte_pkg::*;
  logic [`SB_WIDTH-1:0] meta_q;
  logic [`SB_WIDTH-1:0] sync_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= `SB_RESET;
      sync_q <= `SB_RESET;
    end else if (clk_en) begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  assign out.sum = sync_q;
endmodule
`default_nettype wire

// ### testbench/gpib_ctrl_model.sv
// Purpose: Active controller issuing poll and query reads.
// Assumes: One-cycle strobes. Notes: None.
`timescale 1ns/100ps
`default_nettype none
module gpib_ctrl_model (
  input wire logic clk,
  output logic poll_rd = 1'b0,
  output logic query_rd = 1'b0
);
  task automatic read(input bit poll);
    @(negedge clk);
    if (poll) poll_rd = 1'b1;
    else query_rd = 1'b1;
    @(negedge clk);
    poll_rd = 1'b0;
    query_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/sbs_sva.sv
// Purpose: Port assertions for the summarizer.
// Assumes: Bound from the bench. Notes: None.
`timescale 1ns/100ps
`default_nettype none
module sbs_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Strobes
  input wire logic poll_rd,
  input wire logic query_rd,
  input wire logic clear_status,
  // Results
  input wire logic srq,
  input wire logic mss,
  input wire logic read_valid,
  input wire status_byte_pkg::sbyte_t status_byte,
  input wire status_byte_pkg::sbyte_t poll_byte,
  input wire status_byte_pkg::sbyte_t query_byte
);
  import status_byte_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_unused_zero: assert property (status_byte[2] == 1'b0 && status_byte[6] == 1'b0)
    else $error("unused bit set");
  a_poll_value: assert property (clk_en && poll_rd |=>
    poll_byte == ($past(status_byte) | {1'b0, $past(srq), 6'h00})) else $error("bad poll byte");
  a_query_value: assert property (clk_en && query_rd |=>
    query_byte == ($past(status_byte) | {1'b0, $past(mss), 6'h00})) else $error("bad query byte");
  a_poll_clears: assert property ((clk_en && poll_rd) ##1 !$rose(mss) |-> !srq)
    else $error("poll left srq");
  a_clear_drops: assert property ((clk_en && clear_status) ##1 !$rose(mss) |-> !srq)
    else $error("clear left srq");
  a_srq_cause: assert property ($rose(srq) |-> $rose(mss))
    else $error("srq without rise");
  a_srq_sets: assert property ($rose(mss) |-> srq)
    else $error("srq missed");
  a_mss_none: assert property ((status_byte == 8'h00) [*2] |-> !mss)
    else $error("mss with empty byte");
  a_valid_pulse: assert property (clk_en && (poll_rd || query_rd) |=> read_valid)
    else $error("read not answered");
endmodule
`default_nettype wire

// ### testbench/status_byte_summarizer_test.sv
// Purpose: Self-checking bench for the summarizer.
// Assumes: clk_en drops for short spells to check that the status byte, MSS and SRQ freeze.
// Notes: The mask lands before the summaries, so the model tracks that step.
`timescale 1ns/100ps
`default_nettype none
module status_byte_summarizer_test;
  import status_byte_pkg::*;
  logic clk = 1'b0, reset = 1'b1, clr = 1'b0, en = 1'b1, valid, srq, mss, prd, qrd, rqs = 1'b0, e, mid, pm = 1'b0;
  logic [5:0] s = 6'h00;
  sbyte_t m = 8'h00, sb, so = 8'h00, stb, pb, qb;
  logic [8:0] q[$];
  int miscompares = 0, tests_run = 0, cycles = 0;
  always #2.5 clk = ~clk;
  gpib_ctrl_model ctrl (.clk(clk), .poll_rd(prd), .query_rd(qrd));
  status_byte_summarizer dut (.clk(clk), .reset(reset), .clk_en(en), .hw1_sum(s[0]), .hw2_sum(s[1]),
    .ques_sum(s[2]), .mav(s[3]), .esb_sum(s[4]), .oper_sum(s[5]), .sre_mask(m), .clear_status(clr),
    .poll_rd(prd), .query_rd(qrd), .status_byte(stb), .poll_byte(pb), .query_byte(qb),
    .read_valid(valid), .srq(srq), .mss(mss));
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (++cycles == 8000) begin
      miscompares++;
      close_out();
    end
    if (valid === 1'b1) begin
      if (q[0][8]) chk("poll_byte", q[0][7:0], pb);
      else chk("query_byte", q[0][7:0], qb);
      void'(q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h8252_f200));
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (200) begin
      @(negedge clk);
      s = 6'($urandom);
      m = 8'($urandom);
      sb = {s[5], 1'b0, s[4:2], 1'b0, s[1:0]};
      mid = |(so & m & 8'hbf);
      e = |(sb & m & 8'hbf);
      if ((mid && !pm) || (e && !mid)) rqs = 1'b1;
      repeat (6) @(negedge clk);
      chk("status_byte", sb, stb);
      chk("mss_srq", {6'h00, e, rqs}, {6'h00, mss, srq});
      if ($urandom % 4 == 1) begin
        en = 1'b0;
        s = ~s;
        repeat (3) @(negedge clk);
        chk("frozen_byte", sb, stb);
        chk("frozen_srq", {6'h00, e, rqs}, {6'h00, mss, srq});
        s = ~s;
        en = 1'b1;
      end
      if ($urandom % 4 == 0) begin
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        rqs = 1'b0;
      end
      q.push_back({1'b0, sb | {1'b0, e, 6'h00}});
      ctrl.read(1'b0);
      q.push_back({1'b1, sb | {1'b0, rqs, 6'h00}});
      ctrl.read(1'b1);
      rqs = 1'b0;
      so = sb;
      pm = e;
    end
    repeat (3) @(negedge clk);
    chk("reads_left", 8'h00, 8'(q.size()));
    close_out();
  end
endmodule
bind status_byte_summarizer sbs_sva sva (.clk(clk), .reset(reset), .clk_en(clk_en), .poll_rd(poll_rd),
  .query_rd(query_rd), .clear_status(clear_status), .srq(srq), .mss(mss), .status_byte(status_byte),
  .poll_byte(poll_byte), .query_byte(query_byte), .read_valid(read_valid));
`default_nettype wire
